// File: dv/serial_far_end.sv
`timescale 1ns/1ps
module serial_far_end #(
    parameter int BUSY_LEN = 40
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic baud_i,
    input wire logic load_i,
    input wire logic pre_i,
    input wire logic brk_i,
    output logic rxd_o,
    output logic rdy_o,
    output logic busy_o
);
    int cnt;
    initial rxd_o = 1'b1;
    // Fixed busy span per byte or preamble
    always @(posedge clk_i) begin
        if (rst_i)
            cnt <= 0;
        else if (load_i || pre_i)
            cnt <= BUSY_LEN;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    // Busy follows the pulses at once, else the done flag could reopen
    assign busy_o = cnt != 0 || load_i || pre_i || brk_i;
    assign rdy_o = !busy_o;
    task automatic tick;
        do @(posedge clk_i); while (baud_i !== 1'b1);
    endtask
    // Line idles high between frames; noise hits one sample of data bit 0
    task automatic send(input logic [7:0] d, input bit nz, input bit bs,
            input int wt);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            for (int t = 0; t < 16; t++) begin
                tick();
                rxd_o <= (f[i] ^ (nz && i == 1 && t == 8))
                    && !(bs && i == 9 && t < 10);
            end
        end
        repeat (wt) tick();
    endtask
endmodule

// File: dv/tb_uart_status_flags.sv
`timescale 1ns/1ps
module tb_uart_status_flags;
    logic clk, rst, psel, pen, pwr, baud, rxd, rdy, busy;
    logic pready, pslverr, load, pre, brk, irq, err;
    logic [3:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] txd, expf, arm, d;
    logic [7:0] rxq[$];
    int errors, samples_checked, loads, pres, seed;

    uart_status_flags #(.ADDR_W(4)) i_uart_status_flags (
        .CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .RXD_I(rxd), .BAUD_X16_I(baud), .TX_SHIFT_READY_I(rdy),
        .TX_SHIFT_BUSY_I(busy), .TX_LOAD_O(load), .TX_DATA_O(txd),
        .TX_PREAMBLE_O(pre), .TX_BREAK_O(brk), .IRQ_O(irq)
    );
    serial_far_end i_serial_far_end (
        .clk_i(clk), .rst_i(rst), .baud_i(baud), .load_i(load),
        .pre_i(pre), .brk_i(brk), .rxd_o(rxd), .rdy_o(rdy), .busy_o(busy)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        baud <= ~baud;
        if (load === 1'b1) loads++;
        if (pre === 1'b1) pres++;
    end

    task end_sim;
        $display("errors=%0d checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    // One idle edge first, so back-to-back calls never drive twice at once
    task apb(input logic w, input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk);
        pen <= 1'b1;
        // Only the watchdog may end a wait for the answer
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] v);
        apb(1'b1, a, {24'h0, v});
        if (a == 4'h8) arm = 8'h00;
    endtask
    task rd_st;
        apb(1'b0, 4'h0, 32'h0);
        check("status", rd, {24'h0, expf});
        arm = expf;
    endtask
    task rd_dat;
        apb(1'b0, 4'h8, 32'h0);
        check("data", {24'h0, rd[7:0]}, {24'h0, rxq[$]});
        expf &= ~(arm & 8'h3f);
        arm = 8'h00;
    endtask
    // Model: overrun drops the byte and its error bits
    task rx(input logic [7:0] v, input logic [2:0] fl, input bit idl,
            input int wt);
        i_serial_far_end.send(v, fl[2], fl[1], wt);
        if (expf[5]) expf[3] = 1'b1;
        else begin
            expf |= {3'b001, idl, 1'b0, fl};
            rxq.push_back(v);
        end
    endtask

    initial begin
        #400000;
        errors++;
        end_sim();
    end
    initial begin
        {psel, pen, pwr, baud, rst} = 5'h1;
        paddr = 4'h0;
        pwdata = 32'h0;
        expf = 8'hc0;
        arm = 8'h00;
        seed = $urandom(32'he2d1861a);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wr(4'h8, 8'h33);
        wr(4'h0, 8'hff);
        rd_st;
        apb(1'b0, 4'h2, 32'h0);
        check("slverr", 32'(err), 32'h1);
        rd_st;
        wr(4'h4, 8'h2c);
        expf = 8'h80;
        rd_st;
        repeat (50) @(posedge clk);
        expf = 8'hc0;
        rd_st;
        wr(4'h8, 8'h5a);
        expf = 8'h80;
        repeat (3) @(posedge clk);
        check("txdata", 32'(txd), 32'h5a);
        rd_st;
        wr(4'h8, 8'ha5);
        expf = 8'h00;
        rd_st;
        repeat (100) @(posedge clk);
        expf = 8'hc0;
        rd_st;
        check("loads", 32'(loads), 32'h2);
        check("txdata", 32'(txd), 32'ha5);
        wr(4'h4, 8'h2d);
        expf = 8'h80;
        rd_st;
        check("break", 32'(brk), 32'h1);
        wr(4'h4, 8'h2c);
        repeat (5) @(posedge clk);
        expf = 8'hc0;
        rd_st;
        wr(4'h4, 8'h24);
        wr(4'h4, 8'h2c);
        // The pulse comes one cycle after the access edge
        repeat (2) @(posedge clk);
        check("preamble", 32'(pres), 32'h2);
        repeat (60) @(posedge clk);
        rx($urandom, 3'h0, 1'b1, 200);
        check("irq", 32'(irq), 32'h1);
        rd_st;
        rd_dat;
        repeat (2) @(posedge clk);
        check("irq", 32'(irq), 32'h0);
        repeat (400) @(posedge clk);
        rd_st;
        rx($urandom, 3'h0, 1'b1, 200);
        rd_dat;
        rd_st;
        rx($urandom, 3'h4, 1'b0, 200);
        rd_st;
        rd_dat;
        rd_st;
        wr(4'hc, 8'h02);
        for (int k = 0; k < 3; k++) begin
            d = $urandom;
            if (^d != (k == 2)) d[7] = ~d[7];
            rx(d, 3'h4 >> k, 1'b1, 200);
            rd_st;
            rd_dat;
            rd_st;
        end
        wr(4'hc, 8'h00);
        rx(8'hff, 3'h0, 1'b1, 100);
        rd_st;
        rd_dat;
        wr(4'hc, 8'h04);
        rx(8'hff, 3'h0, 1'b0, 100);
        rd_st;
        repeat (200) @(posedge clk);
        expf[4] = 1'b1;
        rd_st;
        rd_dat;
        rd_st;
        end_sim();
    end
endmodule

// File: dv/uart_status_flags_monitor.sv
`timescale 1ns/1ps
module uart_status_flags_monitor #(
    parameter int ADDR_W = 4
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic TX_SHIFT_READY_I,
    input wire logic TX_LOAD_O,
    input wire logic [7:0] TX_DATA_O,
    input wire logic TX_PREAMBLE_O,
    input wire logic TX_BREAK_O
);
    logic ctrl_wr;
    assign ctrl_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I
        && PADDR_I == ADDR_W'(serial_flags_pkg::OFS_CTRL2);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    sequence s_setup;
        PSEL_I && !PENABLE_I;
    endsequence
    sequence s_access;
        PSEL_I && PENABLE_I && PREADY_O;
    endsequence
    a_setup_gets_ready: assert property (s_setup |=> s_access)
        else $error("no ready after setup");
    a_ready_in_access: assert property (PREADY_O |->
        PSEL_I && PENABLE_I && $past(PSEL_I && !PENABLE_I))
        else $error("ready outside access phase");
    a_error_zero_data: assert property (PSLVERR_O |-> PREADY_O
        && PRDATA_O == 32'h0) else $error("bad error response");
    a_misaligned_refused: assert property
        (s_setup ##0 (PADDR_I[1:0] != 2'h0) |=> PSLVERR_O)
        else $error("unmapped access not refused");
    a_status_upper_zero: assert property (s_access ##0 (!PWRITE_I
        && PADDR_I == '0) |-> PRDATA_O[31:8] == 24'h0)
        else $error("status upper bits not zero");
    a_load_one_cycle: assert property (TX_LOAD_O |=> !TX_LOAD_O)
        else $error("load longer than one cycle");
    a_load_needs_ready: assert property
        (TX_LOAD_O |-> $past(TX_SHIFT_READY_I))
        else $error("load while shifter not ready");
    a_data_held: assert property ($changed(TX_DATA_O) |-> TX_LOAD_O)
        else $error("byte changed without load");
    a_preamble_cause: assert property (TX_PREAMBLE_O |-> $past(ctrl_wr)
        && !$past(TX_PREAMBLE_O))
        else $error("preamble without control write");
    a_break_cause: assert property ($changed(TX_BREAK_O) |->
        $past(ctrl_wr) || $past(ctrl_wr, 2))
        else $error("break changed without control write");
endmodule

bind uart_status_flags uart_status_flags_monitor #(.ADDR_W(ADDR_W)) i_mon (
    .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .TX_SHIFT_READY_I(TX_SHIFT_READY_I), .TX_LOAD_O(TX_LOAD_O),
    .TX_DATA_O(TX_DATA_O), .TX_PREAMBLE_O(TX_PREAMBLE_O),
    .TX_BREAK_O(TX_BREAK_O)
);

// File: logic/serial_flags_pkg.sv
package serial_flags_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_CTRL1 = 8'h0c;

    // Register indices returned by the decoder
    localparam logic [1:0] IDX_STATUS = 2'h0;
    localparam logic [1:0] IDX_CTRL2 = 2'h1;
    localparam logic [1:0] IDX_DATA = 2'h2;
    localparam logic [1:0] IDX_CTRL1 = 2'h3;

    // Status one flag positions
    localparam int EMPTY_BIT = 7;
    localparam int DONE_BIT = 6;
    localparam int FULL_BIT = 5;
    localparam int IDLE_BIT = 4;
    localparam int OVR_BIT = 3;
    localparam int NOISE_BIT = 2;
    localparam int FRAME_BIT = 1;
    localparam int PARITY_BIT = 0;
    localparam logic [7:0] STATUS_RESET = 8'hc0;
    localparam logic [7:0] RX_CLEAR_MASK = 8'h3f;
    localparam logic [7:0] TX_CLEAR_MASK = 8'hc0;

    // Control two positions; bits 7..4 line up with flags 7..4
    localparam int TXEN_BIT = 3;
    localparam int RE_BIT = 2;
    localparam int BREAK_BIT = 0;
    localparam logic [7:0] CTRL2_RESET = 8'h00;

    // Control one positions
    localparam int M_BIT = 4;
    localparam int ITYPE_BIT = 2;
    localparam int PAREN_BIT = 1;
    localparam int PT_BIT = 0;
    localparam logic [7:0] CTRL1_MASK = 8'h17;
    localparam logic [7:0] CTRL1_RESET = 8'h00;

    // Receive timing in ticks of the 16x baud enable
    localparam int OVERSAMPLE = 16;
    localparam int CHAR_BITS_SHORT = 10;
    localparam int CHAR_BITS_LONG = 11;
    localparam logic [3:0] START_SAMPLE_FIRST = 4'h3;
    localparam logic [3:0] START_SAMPLE_LAST = 4'h9;
    localparam logic [3:0] BIT_SAMPLE_FIRST = 4'h7;
    localparam logic [3:0] BIT_SAMPLE_LAST = 4'h9;
    localparam logic [3:0] BIT_LAST_TICK = 4'hf;
    localparam logic [2:0] START_MAJORITY = 3'h4;
    localparam logic [2:0] BIT_MAJORITY = 3'h2;
    localparam logic [7:0] IDLE_TICKS_SHORT = 8'(CHAR_BITS_SHORT * OVERSAMPLE);
    localparam logic [7:0] IDLE_TICKS_LONG = 8'(CHAR_BITS_LONG * OVERSAMPLE);

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } rx_state_e;

endpackage

// File: logic/uart_status_flags.sv
`timescale 1ns/1ps
module uart_status_flags #(
    parameter int ADDR_W = 4
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic RXD_I,
    input wire logic BAUD_X16_I,
    input wire logic TX_SHIFT_READY_I,
    input wire logic TX_SHIFT_BUSY_I,
    output logic TX_LOAD_O,
    output logic [7:0] TX_DATA_O,
    output logic TX_PREAMBLE_O,
    output logic TX_BREAK_O,
    output logic IRQ_O
);

    if (ADDR_W < 4 || ADDR_W > 8) begin : g_check
        $error("ADDR_W must lie between 4 and 8");
    end

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] armed;
        logic [7:0] ctrl2;
        logic [7:0] ctrl1;
        logic [7:0] txbuf;
        logic [7:0] txd;
        logic tx_load;
        logic tx_pre;
        logic tx_brk;
        logic tx_pend;
        serial_flags_pkg::rx_state_e rx_state;
        logic [3:0] rx_sub;
        logic [3:0] rx_bit;
        logic [2:0] rx_ones;
        logic [8:0] rx_sh;
        logic rx_noise;
        logic [8:0] rxbuf;
        logic [7:0] idle_cnt;
        logic idle_allow;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } state_s;

    state_s s;
    state_s next_s;

    // Returns {hit, index}; anything else answers with an error
    function automatic logic [2:0] decode(input logic [7:0] a);
        case (a)
            serial_flags_pkg::OFS_STATUS:
                decode = {1'b1, serial_flags_pkg::IDX_STATUS};
            serial_flags_pkg::OFS_CTRL2:
                decode = {1'b1, serial_flags_pkg::IDX_CTRL2};
            serial_flags_pkg::OFS_DATA:
                decode = {1'b1, serial_flags_pkg::IDX_DATA};
            serial_flags_pkg::OFS_CTRL1:
                decode = {1'b1, serial_flags_pkg::IDX_CTRL1};
            default: decode = 3'h0;
        endcase
    endfunction

    always_comb begin
        logic [2:0] dec;
        logic acc;
        logic [7:0] newc;
        logic [2:0] tot;
        logic [3:0] first;
        logic [3:0] last;
        logic bitval;
        logic [7:0] limit;
        logic cnt_en;
        logic [3:0] nbits;
        dec = 3'h0;
        acc = 1'b0;
        newc = 8'h00;
        tot = 3'h0;
        first = 4'h0;
        last = 4'h0;
        bitval = 1'b0;
        limit = 8'h00;
        cnt_en = 1'b0;
        nbits = 4'h0;
        next_s = s;
        next_s.tx_load = 1'b0;
        next_s.tx_pre = 1'b0;
        if (TX_SHIFT_BUSY_I) begin
            next_s.tx_pend = 1'b0;
        end

        // Data is latched in setup so the access phase answers at once
        dec = decode(8'(PADDR_I));
        acc = PSEL_I && PENABLE_I && s.pready;
        if (PSEL_I && !PENABLE_I) begin
            next_s.pready = 1'b1;
            next_s.pslverr = !dec[2];
            case (dec[1:0])
                serial_flags_pkg::IDX_STATUS: next_s.prdata = {24'h0, s.flags};
                serial_flags_pkg::IDX_CTRL2: next_s.prdata = {24'h0, s.ctrl2};
                serial_flags_pkg::IDX_DATA: next_s.prdata = {23'h0, s.rxbuf};
                default: next_s.prdata = {24'h0, s.ctrl1};
            endcase
            if (!dec[2]) begin
                next_s.prdata = 32'h0;
            end
        end else if (acc) begin
            next_s.pready = 1'b0;
            next_s.pslverr = 1'b0;
        end

        if (acc && dec[2] && PWRITE_I) begin
            newc = PWDATA_I[7:0];
            case (dec[1:0])
                serial_flags_pkg::IDX_CTRL2: begin
                    if (!s.ctrl2[serial_flags_pkg::TXEN_BIT]
                        && newc[serial_flags_pkg::TXEN_BIT]) begin
                        next_s.tx_pre = 1'b1;
                        next_s.tx_pend = 1'b1;
                        if (s.armed[serial_flags_pkg::DONE_BIT]) begin
                            next_s.flags[serial_flags_pkg::DONE_BIT] =
                                1'b0;
                        end
                    end
                    if (newc[serial_flags_pkg::BREAK_BIT]) begin
                        next_s.tx_pend = 1'b1;
                        if (s.armed[serial_flags_pkg::DONE_BIT]) begin
                            next_s.flags[serial_flags_pkg::DONE_BIT] =
                                1'b0;
                        end
                    end
                    next_s.armed[serial_flags_pkg::DONE_BIT] = 1'b0;
                    next_s.ctrl2 = newc;
                end
                serial_flags_pkg::IDX_DATA: begin
                    next_s.txbuf = newc;
                    // Unarmed writes still fill the buffer, as software may retry
                    next_s.flags = s.flags
                        & ~(s.armed
                        & serial_flags_pkg::TX_CLEAR_MASK);
                    next_s.armed = s.armed & ~serial_flags_pkg::TX_CLEAR_MASK;
                end
                serial_flags_pkg::IDX_CTRL1: begin
                    next_s.ctrl1 = newc & serial_flags_pkg::CTRL1_MASK;
                end
                default: begin
                    next_s.flags = s.flags;
                end
            endcase
        end else if (acc && dec[2]) begin
            case (dec[1:0])
                serial_flags_pkg::IDX_STATUS: begin
                    next_s.armed = s.prdata[7:0];
                end
                serial_flags_pkg::IDX_DATA: begin
                    next_s.flags = s.flags
                        & ~(s.armed
                        & serial_flags_pkg::RX_CLEAR_MASK);
                    next_s.armed = s.armed & ~serial_flags_pkg::RX_CLEAR_MASK;
                end
                default: begin
                    next_s.armed = s.armed;
                end
            endcase
        end

        // Transmit side; sets come after clears so a set wins
        if (!s.flags[serial_flags_pkg::EMPTY_BIT]
            && s.ctrl2[serial_flags_pkg::TXEN_BIT] && TX_SHIFT_READY_I) begin
            next_s.tx_load = 1'b1;
            next_s.txd = s.txbuf;
            next_s.flags[serial_flags_pkg::EMPTY_BIT] = 1'b1;
        end
        next_s.tx_brk = next_s.ctrl2[serial_flags_pkg::TXEN_BIT]
            && next_s.ctrl2[serial_flags_pkg::BREAK_BIT];
        if (next_s.flags[serial_flags_pkg::EMPTY_BIT] && !TX_SHIFT_BUSY_I
            && !next_s.tx_pend && !next_s.tx_brk && !next_s.tx_load) begin
            next_s.flags[serial_flags_pkg::DONE_BIT] = 1'b1;
        end

        // Receiver, advanced by the 16x baud enable
        nbits = s.ctrl1[serial_flags_pkg::M_BIT] ? 4'h9 : 4'h8;
        limit = s.ctrl1[serial_flags_pkg::M_BIT]
            ? serial_flags_pkg::IDLE_TICKS_LONG
            : serial_flags_pkg::IDLE_TICKS_SHORT;
        tot = s.rx_ones + {2'h0, RXD_I};
        if (s.rx_state == serial_flags_pkg::RX_START) begin
            first = serial_flags_pkg::START_SAMPLE_FIRST;
            last = serial_flags_pkg::START_SAMPLE_LAST;
        end else begin
            first = serial_flags_pkg::BIT_SAMPLE_FIRST;
            last = serial_flags_pkg::BIT_SAMPLE_LAST;
        end
        bitval = tot >= serial_flags_pkg::BIT_MAJORITY;
        if (!s.ctrl2[serial_flags_pkg::RE_BIT]) begin
            next_s.rx_state = serial_flags_pkg::RX_IDLE;
            next_s.idle_cnt = 8'h00;
        end else if (BAUD_X16_I) begin
            next_s.rx_sub = s.rx_sub + 4'h1;
            if (s.rx_sub >= first && s.rx_sub <= last) begin
                next_s.rx_ones = tot;
            end
            if (s.rx_sub == serial_flags_pkg::BIT_LAST_TICK) begin
                next_s.rx_ones = 3'h0;
            end
            case (s.rx_state)
                serial_flags_pkg::RX_IDLE: begin
                    if (!RXD_I) begin
                        next_s.rx_state = serial_flags_pkg::RX_START;
                        next_s.rx_sub = 4'h1;
                        next_s.rx_ones = 3'h0;
                        next_s.rx_noise = 1'b0;
                        next_s.rx_sh = 9'h000;
                    end
                end
                serial_flags_pkg::RX_START: begin
                    if (s.rx_sub == last) begin
                        if (tot >= serial_flags_pkg::START_MAJORITY) begin
                            // A glitch, not a start bit
                            next_s.rx_state = serial_flags_pkg::RX_IDLE;
                        end
                        next_s.rx_noise = tot != 3'h0;
                    end
                    if (s.rx_sub == serial_flags_pkg::BIT_LAST_TICK) begin
                        next_s.rx_state = serial_flags_pkg::RX_DATA;
                        next_s.rx_bit = 4'h0;
                    end
                end
                serial_flags_pkg::RX_DATA: begin
                    if (s.rx_sub == last) begin
                        next_s.rx_sh = {bitval, s.rx_sh[8:1]};
                        next_s.rx_noise = s.rx_noise
                            || (tot == 3'h1) || (tot == 3'h2);
                    end
                    if (s.rx_sub == serial_flags_pkg::BIT_LAST_TICK) begin
                        next_s.rx_bit = s.rx_bit + 4'h1;
                        if (s.rx_bit == nbits - 4'h1) begin
                            next_s.rx_state = serial_flags_pkg::RX_STOP;
                        end
                    end
                end
                serial_flags_pkg::RX_STOP: begin
                    if (s.rx_sub == last) begin
                        next_s.rx_state = serial_flags_pkg::RX_IDLE;
                        if (s.flags[serial_flags_pkg::FULL_BIT]) begin
                            next_s.flags[serial_flags_pkg::OVR_BIT] =
                                1'b1;
                        end else begin
                            next_s.rxbuf = s.ctrl1[serial_flags_pkg::M_BIT]
                                ? s.rx_sh : {1'b0, s.rx_sh[8:1]};
                            next_s.flags[serial_flags_pkg::FULL_BIT] =
                                1'b1;
                            next_s.flags[serial_flags_pkg::NOISE_BIT] =
                                s.rx_noise
                                || (tot == 3'h1) || (tot == 3'h2);
                            next_s.flags[serial_flags_pkg::FRAME_BIT] =
                                !bitval;
                            next_s.flags[serial_flags_pkg::PARITY_BIT] =
                                s.ctrl1[serial_flags_pkg::PAREN_BIT]
                                && ((^s.rx_sh)
                                != s.ctrl1[serial_flags_pkg::PT_BIT]);
                            next_s.idle_allow = 1'b1;
                        end
                    end
                end
                default: begin
                    next_s.rx_state = serial_flags_pkg::RX_IDLE;
                end
            endcase

            // Idle timer; a low sample restarts it
            if (s.ctrl1[serial_flags_pkg::ITYPE_BIT]) begin
                cnt_en = s.rx_state == serial_flags_pkg::RX_IDLE;
            end else begin
                cnt_en = s.rx_state != serial_flags_pkg::RX_START;
            end
            if (!RXD_I || !cnt_en) begin
                next_s.idle_cnt = 8'h00;
            end else if (s.idle_cnt != limit) begin
                next_s.idle_cnt = s.idle_cnt + 8'h01;
                if (s.idle_cnt == limit - 8'h01 && s.idle_allow) begin
                    next_s.flags[serial_flags_pkg::IDLE_BIT] = 1'b1;
                    next_s.idle_allow = 1'b0;
                end
            end
        end

        next_s.irq = |(next_s.ctrl2[7:4] & next_s.flags[7:4]);
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            s <= '0;
            s.flags <= serial_flags_pkg::STATUS_RESET;
            s.ctrl2 <= serial_flags_pkg::CTRL2_RESET;
            s.ctrl1 <= serial_flags_pkg::CTRL1_RESET;
            s.rx_state <= serial_flags_pkg::RX_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign PRDATA_O = s.prdata;
    assign PREADY_O = s.pready;
    assign PSLVERR_O = s.pslverr;
    assign TX_LOAD_O = s.tx_load;
    assign TX_DATA_O = s.txd;
    assign TX_PREAMBLE_O = s.tx_pre;
    assign TX_BREAK_O = s.tx_brk;
    assign IRQ_O = s.irq;

endmodule
